// ===== src/cbc_pkg.sv
// package for the branch/call/clear/compare execution block: register
// offsets, status bit positions, masks, reset values and shared types.
// assumes a 32-bit avalon-mm slave with byte addresses, one word per reg.
package cbc_pkg;

  // ==========================================================
  // register map (byte addresses, one aligned word each)
  localparam logic [7:0] OFS_CTRL     = 8'h00;
  localparam logic [7:0] OFS_PROG_CNT = 8'h04;
  localparam logic [7:0] OFS_STK_PTR  = 8'h08;
  localparam logic [7:0] OFS_STATUS   = 8'h0c;
  localparam logic [7:0] OFS_SRC_VAL  = 8'h10;
  localparam logic [7:0] OFS_DST_VAL  = 8'h14;
  localparam logic [7:0] OFS_REG_VAL  = 8'h18;
  localparam logic [7:0] OFS_OFFSET   = 8'h1c;
  localparam logic [7:0] OFS_EFF_ADDR = 8'h20;
  localparam logic [7:0] OFS_STK_DATA = 8'h24;
  localparam logic [7:0] OFS_DST_RES  = 8'h28;
  localparam logic [7:0] OFS_EXEC_ST  = 8'h2c;

  // ==========================================================
  // status register layout
  localparam int STAT_C    = 0;
  localparam int STAT_Z    = 1;
  localparam int STAT_N    = 2;
  localparam int STAT_IRQ  = 3;
  localparam int STAT_CORE = 4;
  localparam int STAT_OSC  = 5;
  localparam int STAT_V    = 8;
  localparam logic [15:0] MASK_C = 16'h0001;
  localparam logic [15:0] MASK_Z = 16'h0002;
  localparam logic [15:0] MASK_N = 16'h0004;

  // ==========================================================
  // reset values and step sizes
  localparam logic [19:0] PROG_CNT_RST = 20'h00000;
  localparam logic [19:0] STK_PTR_RST  = 20'h00000;
  localparam logic [15:0] STATUS_RST   = 16'h0000;
  localparam logic [19:0] STK_STEP     = 20'h00002;
  localparam logic [19:0] PTR_STEP     = 20'h00002;
  localparam logic [3:0]  LOW64K_TOP   = 4'h0;

  // ==========================================================
  // types
  typedef enum logic [2:0] {
    OP_JUMP_UNCOND, OP_CALL, OP_ZERO_DEST, OP_CARRY_CLR,
    OP_NEG_CLR, OP_ZERO_FLAG_CLR, OP_COMPARE
  } cbc_op_t;

  typedef enum logic [2:0] {
    MD_REGISTER, MD_INDEXED, MD_SYMBOLIC, MD_ABSOLUTE,
    MD_INDIRECT, MD_AUTOINC, MD_IMMEDIATE
  } cbc_mode_t;

  // ctrl word: op in [2:0], byte form in [3], mode in [6:4]
  typedef struct packed {
    cbc_mode_t mode;
    logic      byte_op;
    cbc_op_t   op;
  } cbc_cmd_t;

  typedef struct packed {
    logic v;
    logic n;
    logic z;
    logic c;
  } cbc_flags_t;

  typedef enum logic [1:0] {S_IDLE, S_EVAL, S_PUSH, S_LOAD} cbc_state_t;

endpackage : cbc_pkg

// ===== src/cbc_compare_alu.sv
// compare datapath: dst + ~src + 1, flags only, word or byte form.
// assumes operands are already resolved; result is combinational.
`timescale 1ns/1ps
module cbc_compare_alu (
  input  wire logic [15:0]        src_in,
  input  wire logic [15:0]        dst_in,
  input  wire logic               byte_op_in,
  output cbc_pkg::cbc_flags_t     flags_out
);
  logic [16:0] sum_w;
  logic [8:0]  sum_b;
  logic        res_msb;
  logic        src_msb;
  logic        dst_msb;
  logic        res_zero;
  logic        carry;

  // ==========================================================
  // adder in both widths
  assign sum_w = {1'b0, dst_in} + {1'b0, ~src_in} + 17'h00001;
  assign sum_b = {1'b0, dst_in[7:0]} + {1'b0, ~src_in[7:0]} + 9'h001;

  // msb picks bit 7 or bit 15 by operand form
  always_comb begin
    if (byte_op_in) begin
      res_msb  = sum_b[7];
      src_msb  = src_in[7];
      dst_msb  = dst_in[7];
      res_zero = (sum_b[7:0] == 8'h00);
      carry    = sum_b[8];
    end else begin
      res_msb  = sum_w[15];
      src_msb  = src_in[15];
      dst_msb  = dst_in[15];
      res_zero = (sum_w[15:0] == 16'h0000);
      carry    = sum_w[16];
    end
  end

  assign flags_out.n = res_msb;
  assign flags_out.z = res_zero;
  assign flags_out.c = carry;
  // sign of src differs from dst and result sign left dst's sign
  assign flags_out.v = (src_msb != dst_msb) && (res_msb != dst_msb);

endmodule : cbc_compare_alu

// ===== src/cbc_exec_top.sv
// execution block for jump, call, destination clear, flag clears and
// compare, reached over an avalon-mm slave with waitrequest.
// assumes operand fetch is done by software: the word read at the
// effective address (or the immediate word) is placed in the source reg.
`timescale 1ns/1ps

module cbc_exec_top (
  input  wire logic        clk_in,
  input  wire logic        arst_n_in,
  input  wire logic [7:0]  avs_address_in,
  input  wire logic        avs_read_in,
  input  wire logic        avs_write_in,
  input  wire logic [31:0] avs_writedata_in,
  input  wire logic [3:0]  avs_byteenable_in,
  output logic      [31:0] avs_readdata_out,
  output logic             avs_waitrequest_out
);
  cbc_pkg::cbc_state_t state_reg;
  cbc_pkg::cbc_cmd_t   cmd_reg;
  cbc_pkg::cbc_flags_t cmp_flags;
  logic [19:0] prog_cnt_reg;
  logic [19:0] stk_ptr_reg;
  logic [15:0] status_reg;
  logic [15:0] src_val_reg;
  logic [15:0] dst_val_reg;
  logic [19:0] reg_val_reg;
  logic [15:0] offset_reg;
  logic [19:0] eff_addr_reg;
  logic [15:0] stk_data_reg;
  logic [15:0] dst_res_reg;
  logic        dst_wr_reg;
  logic        rd_ack_reg;
  logic [15:0] tmp_reg;
  logic [31:0] cur_word;
  logic [31:0] wr_word;
  logic        busy;
  logic        wr_ok;

  // ==========================================================
  // helpers
  function automatic logic [19:0] sext20(input logic [15:0] v);
    sext20 = {{4{v[15]}}, v};
  endfunction : sext20

  function automatic logic [31:0] be_merge(input logic [31:0] old_v,
                                           input logic [31:0] new_v,
                                           input logic [3:0]  be);
    logic [31:0] m;
    m = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        m[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    be_merge = m;
  endfunction : be_merge

  // target word: register mode uses the register itself, every other
  // mode uses the word software fetched into the source register
  function automatic logic [15:0] target(input cbc_pkg::cbc_mode_t md,
                                         input logic [19:0] rv,
                                         input logic [15:0] sv);
    if (md == cbc_pkg::MD_REGISTER) begin
      target = rv[15:0];
    end else begin
      target = sv;
    end
  endfunction : target

  function automatic logic [19:0] eff_addr(input cbc_pkg::cbc_mode_t md,
                                           input logic [19:0] rv,
                                           input logic [19:0] pcv,
                                           input logic [15:0] ofs);
    if (md == cbc_pkg::MD_INDEXED) begin
      eff_addr = rv + sext20(ofs);
    end else if (md == cbc_pkg::MD_SYMBOLIC) begin
      eff_addr = pcv + sext20(ofs);
    end else if (md == cbc_pkg::MD_ABSOLUTE) begin
      eff_addr = {cbc_pkg::LOW64K_TOP, ofs};
    end else if (md == cbc_pkg::MD_INDIRECT ||
                 md == cbc_pkg::MD_AUTOINC) begin
      eff_addr = rv;
    end else begin
      eff_addr = 20'h00000;
    end
  endfunction : eff_addr

  // ==========================================================
  // avalon slave
  // writes stall while an instruction runs so software never races the
  // sequencer on the same register; reads always answer in two cycles
  assign busy  = (state_reg != cbc_pkg::S_IDLE);
  assign wr_ok = avs_write_in && !busy;
  assign avs_waitrequest_out = (avs_read_in && !rd_ack_reg) ||
                               (avs_write_in && busy);

  always_comb begin
    if (avs_address_in == cbc_pkg::OFS_CTRL) begin
      cur_word = {25'h0000000, cmd_reg};
    end else if (avs_address_in == cbc_pkg::OFS_PROG_CNT) begin
      cur_word = {12'h000, prog_cnt_reg};
    end else if (avs_address_in == cbc_pkg::OFS_STK_PTR) begin
      cur_word = {12'h000, stk_ptr_reg};
    end else if (avs_address_in == cbc_pkg::OFS_STATUS) begin
      cur_word = {16'h0000, status_reg};
    end else if (avs_address_in == cbc_pkg::OFS_SRC_VAL) begin
      cur_word = {16'h0000, src_val_reg};
    end else if (avs_address_in == cbc_pkg::OFS_DST_VAL) begin
      cur_word = {16'h0000, dst_val_reg};
    end else if (avs_address_in == cbc_pkg::OFS_REG_VAL) begin
      cur_word = {12'h000, reg_val_reg};
    end else if (avs_address_in == cbc_pkg::OFS_OFFSET) begin
      cur_word = {16'h0000, offset_reg};
    end else if (avs_address_in == cbc_pkg::OFS_EFF_ADDR) begin
      cur_word = {12'h000, eff_addr_reg};
    end else if (avs_address_in == cbc_pkg::OFS_STK_DATA) begin
      cur_word = {16'h0000, stk_data_reg};
    end else if (avs_address_in == cbc_pkg::OFS_DST_RES) begin
      cur_word = {16'h0000, dst_res_reg};
    end else if (avs_address_in == cbc_pkg::OFS_EXEC_ST) begin
      cur_word = {29'h00000000, cmd_reg.byte_op, dst_wr_reg, busy};
    end else begin
      cur_word = 32'h00000000;
    end
  end

  assign wr_word = be_merge(cur_word, avs_writedata_in, avs_byteenable_in);

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rd_ack_reg       <= 1'b0;
      avs_readdata_out <= 32'h00000000;
    end else begin
      rd_ack_reg <= avs_read_in && !rd_ack_reg;
      if (avs_read_in && !rd_ack_reg) begin
        avs_readdata_out <= cur_word;
      end
    end
  end

  // ==========================================================
  // sequencer
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state_reg <= cbc_pkg::S_IDLE;
      cmd_reg   <= '0;
    end else begin
      case (state_reg)
        cbc_pkg::S_IDLE: begin
          if (wr_ok && avs_address_in == cbc_pkg::OFS_CTRL) begin
            cmd_reg   <= wr_word[6:0];
            state_reg <= cbc_pkg::S_EVAL;
          end
        end
        cbc_pkg::S_EVAL: begin
          if (cmd_reg.op == cbc_pkg::OP_CALL) begin
            state_reg <= cbc_pkg::S_PUSH;
          end else begin
            state_reg <= cbc_pkg::S_LOAD;
          end
        end
        cbc_pkg::S_PUSH: begin
          state_reg <= cbc_pkg::S_LOAD;
        end
        default: begin
          state_reg <= cbc_pkg::S_IDLE;
        end
      endcase
    end
  end

  // target and effective address are latched before the stack moves
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      tmp_reg      <= 16'h0000;
      eff_addr_reg <= 20'h00000;
    end else if (state_reg == cbc_pkg::S_EVAL) begin
      // byte form is ignored: both transfers are word sized
      tmp_reg      <= target(cmd_reg.mode, reg_val_reg, src_val_reg);
      eff_addr_reg <= eff_addr(cmd_reg.mode, reg_val_reg, prog_cnt_reg,
                               offset_reg);
    end
  end

  // ==========================================================
  // program counter and stack
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      prog_cnt_reg <= cbc_pkg::PROG_CNT_RST;
    end else if (wr_ok && avs_address_in == cbc_pkg::OFS_PROG_CNT) begin
      prog_cnt_reg <= wr_word[19:0];
    end else if (state_reg == cbc_pkg::S_LOAD &&
                 (cmd_reg.op == cbc_pkg::OP_JUMP_UNCOND ||
                  cmd_reg.op == cbc_pkg::OP_CALL)) begin
      prog_cnt_reg <= {cbc_pkg::LOW64K_TOP, tmp_reg};
    end
  end

  // limitation: the return word is the low 16 bits, so callers must
  // themselves sit in the lower 64k as the call form requires
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      stk_ptr_reg  <= cbc_pkg::STK_PTR_RST;
      stk_data_reg <= 16'h0000;
    end else if (wr_ok && avs_address_in == cbc_pkg::OFS_STK_PTR) begin
      stk_ptr_reg <= wr_word[19:0];
    end else if (state_reg == cbc_pkg::S_PUSH) begin
      stk_ptr_reg  <= stk_ptr_reg - cbc_pkg::STK_STEP;
      stk_data_reg <= prog_cnt_reg[15:0];
    end
  end

  // ==========================================================
  // status register
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      status_reg <= cbc_pkg::STATUS_RST;
    end else if (wr_ok && avs_address_in == cbc_pkg::OFS_STATUS) begin
      status_reg <= wr_word[15:0];
    end else if (state_reg == cbc_pkg::S_LOAD) begin
      // mode bits are never touched below
      case (cmd_reg.op)
        cbc_pkg::OP_CARRY_CLR: begin
          status_reg <= status_reg & ~cbc_pkg::MASK_C;
        end
        cbc_pkg::OP_NEG_CLR: begin
          status_reg <= status_reg & ~cbc_pkg::MASK_N;
        end
        cbc_pkg::OP_ZERO_FLAG_CLR: begin
          status_reg <= status_reg & ~cbc_pkg::MASK_Z;
        end
        cbc_pkg::OP_COMPARE: begin
          status_reg[cbc_pkg::STAT_C] <= cmp_flags.c;
          status_reg[cbc_pkg::STAT_Z] <= cmp_flags.z;
          status_reg[cbc_pkg::STAT_N] <= cmp_flags.n;
          status_reg[cbc_pkg::STAT_V] <= cmp_flags.v;
        end
        default: begin
          status_reg <= status_reg;
        end
      endcase
    end
  end

  cbc_compare_alu u_alu (
    .src_in     (src_val_reg),
    .dst_in     (dst_val_reg),
    .byte_op_in (cmd_reg.byte_op),
    .flags_out  (cmp_flags)
  );

  // ==========================================================
  // operands and destination result
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      src_val_reg <= 16'h0000;
      dst_val_reg <= 16'h0000;
      offset_reg  <= 16'h0000;
    end else if (wr_ok) begin
      if (avs_address_in == cbc_pkg::OFS_SRC_VAL) begin
        src_val_reg <= wr_word[15:0];
      end else if (avs_address_in == cbc_pkg::OFS_DST_VAL) begin
        dst_val_reg <= wr_word[15:0];
      end else if (avs_address_in == cbc_pkg::OFS_OFFSET) begin
        offset_reg <= wr_word[15:0];
      end
    end
  end

  // the pointer steps only after its word has been taken as target
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      reg_val_reg <= 20'h00000;
    end else if (wr_ok && avs_address_in == cbc_pkg::OFS_REG_VAL) begin
      reg_val_reg <= wr_word[19:0];
    end else if (state_reg == cbc_pkg::S_LOAD &&
                 cmd_reg.mode == cbc_pkg::MD_AUTOINC &&
                 (cmd_reg.op == cbc_pkg::OP_CALL ||
                  cmd_reg.op == cbc_pkg::OP_JUMP_UNCOND)) begin
      reg_val_reg <= reg_val_reg + cbc_pkg::PTR_STEP;
    end
  end

  // compare and flag ops report no destination write; register upper
  // bits therefore stay as they were
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      dst_res_reg <= 16'h0000;
      dst_wr_reg  <= 1'b0;
    end else if (state_reg == cbc_pkg::S_LOAD) begin
      if (cmd_reg.op == cbc_pkg::OP_ZERO_DEST) begin
        dst_res_reg <= 16'h0000;
        dst_wr_reg  <= 1'b1;
      end else begin
        dst_wr_reg  <= 1'b0;
      end
    end
  end

  // ==========================================================
  // assertions
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!arst_n_in);

  logic ld_call;
  logic ld_plain;
  assign ld_call  = state_reg == cbc_pkg::S_LOAD &&
                    cmd_reg.op == cbc_pkg::OP_CALL;
  assign ld_plain = state_reg == cbc_pkg::S_LOAD &&
                    (cmd_reg.op == cbc_pkg::OP_JUMP_UNCOND ||
                     cmd_reg.op == cbc_pkg::OP_CALL ||
                     cmd_reg.op == cbc_pkg::OP_ZERO_DEST);

  property p_jump_pc;
    state_reg == cbc_pkg::S_EVAL && cmd_reg.op == cbc_pkg::OP_JUMP_UNCOND
    |=> ##1 prog_cnt_reg == {4'h0, $past(tmp_reg)};
  endproperty
  a_jump_pc: assert property (p_jump_pc) else $error("jump target");

  property p_flags_kept;
    ld_plain |=> status_reg == $past(status_reg);
  endproperty
  a_flags_kept: assert property (p_flags_kept) else $error("flags moved");

  property p_call_seq;
    state_reg == cbc_pkg::S_EVAL && cmd_reg.op == cbc_pkg::OP_CALL
    |=> state_reg == cbc_pkg::S_PUSH ##1 state_reg == cbc_pkg::S_LOAD
        ##1 state_reg == cbc_pkg::S_IDLE;
  endproperty
  a_call_seq: assert property (p_call_seq) else $error("call order");

  property p_push;
    state_reg == cbc_pkg::S_PUSH
    |=> stk_ptr_reg == $past(stk_ptr_reg) - 20'h00002 &&
        stk_data_reg == $past(prog_cnt_reg[15:0]);
  endproperty
  a_push: assert property (p_push) else $error("push wrong");

  property p_call_low;
    ld_call |=> prog_cnt_reg[19:16] == 4'h0;
  endproperty
  a_call_low: assert property (p_call_low) else $error("pc high bits");

  property p_mode_bits;
    state_reg == cbc_pkg::S_LOAD
    |=> $stable(status_reg[cbc_pkg::STAT_OSC:cbc_pkg::STAT_IRQ]);
  endproperty
  a_mode_bits: assert property (p_mode_bits) else $error("mode bits");

  property p_autoinc;
    ld_call && cmd_reg.mode == cbc_pkg::MD_AUTOINC
    |=> reg_val_reg == $past(reg_val_reg) + 20'h00002;
  endproperty
  a_autoinc: assert property (p_autoinc) else $error("no pointer step");

  property p_cmp_nowrite;
    state_reg == cbc_pkg::S_LOAD && cmd_reg.op == cbc_pkg::OP_COMPARE
    |=> !dst_wr_reg && $stable(reg_val_reg) && $stable(dst_res_reg);
  endproperty
  a_cmp_nowrite: assert property (p_cmp_nowrite) else $error("cmp wrote");

  property p_cmp_zero;
    state_reg == cbc_pkg::S_LOAD && cmd_reg.op == cbc_pkg::OP_COMPARE &&
    src_val_reg == dst_val_reg
    |=> status_reg[cbc_pkg::STAT_Z] && status_reg[cbc_pkg::STAT_C];
  endproperty
  a_cmp_zero: assert property (p_cmp_zero) else $error("equal flags");

  property p_carry_clr;
    state_reg == cbc_pkg::S_LOAD && cmd_reg.op == cbc_pkg::OP_CARRY_CLR
    |=> status_reg == ($past(status_reg) & 16'hfffe);
  endproperty
  a_carry_clr: assert property (p_carry_clr) else $error("carry clear");

  property p_zero_clr;
    state_reg == cbc_pkg::S_LOAD && cmd_reg.op == cbc_pkg::OP_ZERO_FLAG_CLR
    |=> status_reg == ($past(status_reg) & 16'hfffd);
  endproperty
  a_zero_clr: assert property (p_zero_clr) else $error("zero clear");

  c_call: cover property (ld_call);
  c_cmp_eq: cover property (state_reg == cbc_pkg::S_LOAD &&
                            cmd_reg.op == cbc_pkg::OP_COMPARE &&
                            src_val_reg == dst_val_reg);
  c_zero_byte: cover property (state_reg == cbc_pkg::S_LOAD &&
                               cmd_reg.op == cbc_pkg::OP_ZERO_DEST &&
                               cmd_reg.byte_op);

endmodule : cbc_exec_top

// ===== test/cbc_exec_top_tb_top.sv
// self-checking bench for the execution block: avalon-mm register tasks,
// instruction runs and status/result checks.
// assumes the register map, op and mode encodings declared in cbc_pkg.
`timescale 1ns/1ps
module cbc_exec_top_tb_top;
  // ==========================================================
  // signals
  logic        clk_in = 1'b0;
  logic        arst_n_in;
  logic [7:0]  avs_address_in;
  logic        avs_read_in;
  logic        avs_write_in;
  logic [31:0] avs_writedata_in;
  logic [3:0]  avs_byteenable_in;
  logic [31:0] avs_readdata_out;
  logic        avs_waitrequest_out;
  int          errors;
  int          checks;
  // ctrl, status before, src, dst, status expected
  logic [15:0] tv [0:7][0:4] = '{
    '{16'h0003, 16'h013f, 16'h0000, 16'h0000, 16'h013e},
    '{16'h0004, 16'h013f, 16'h0000, 16'h0000, 16'h013b},
    '{16'h0005, 16'h013f, 16'h0000, 16'h0000, 16'h013d},
    '{16'h0006, 16'h0038, 16'h1800, 16'h1800, 16'h003b},
    '{16'h0006, 16'h0038, 16'h0001, 16'h0000, 16'h003c},
    '{16'h0006, 16'h0038, 16'hffff, 16'h7fff, 16'h013c},
    '{16'h000e, 16'h0038, 16'hab01, 16'hcd80, 16'h0139},
    '{16'h000e, 16'h013f, 16'h1205, 16'h3405, 16'h003b}};

  cbc_exec_top dut (
    .clk_in              (clk_in),
    .arst_n_in           (arst_n_in),
    .avs_address_in      (avs_address_in),
    .avs_read_in         (avs_read_in),
    .avs_write_in        (avs_write_in),
    .avs_writedata_in    (avs_writedata_in),
    .avs_byteenable_in   (avs_byteenable_in),
    .avs_readdata_out    (avs_readdata_out),
    .avs_waitrequest_out (avs_waitrequest_out)
  );

  always #2.5 clk_in = ~clk_in;

  // ==========================================================
  // tasks
  task automatic close_out;
    $display("errors %0d checks %0d", errors, checks);
    if (errors == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : close_out

  // entered right after an edge; one idle edge at the end keeps the
  // strobe from being lowered and raised in the same time step
  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] rd);
    int n;
    n = 0;
    avs_address_in   <= a;
    avs_writedata_in <= wd;
    avs_write_in     <= wr;
    avs_read_in      <= ~wr;
    do begin
      @(posedge clk_in);
      n++;
      if (n > 100) begin
        $display("[ERR] %0t bus timeout", $time);
        errors++;
        close_out();
      end
    end while (avs_waitrequest_out !== 1'b0);
    rd = avs_readdata_out;
    avs_write_in <= 1'b0;
    avs_read_in  <= 1'b0;
    @(posedge clk_in);
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] v;
    bus(1'b1, a, d, v);
  endtask : wr

  task automatic chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] v;
    bus(1'b0, a, 32'h0, v);
    checks++;
    if (v !== exp) begin
      $display("[ERR] %0t addr %h got %h exp %h", $time, a, v, exp);
      errors++;
    end
  endtask : chk

  // start an instruction and poll the busy bit under a bound
  task automatic run(input logic [31:0] c);
    logic [31:0] v;
    int          n;
    n = 0;
    bus(1'b1, cbc_pkg::OFS_CTRL, c, v);
    do begin
      bus(1'b0, cbc_pkg::OFS_EXEC_ST, 32'h0, v);
      n++;
      if (n > 20) begin
        $display("[ERR] %0t instruction never finished", $time);
        errors++;
        close_out();
      end
    end while (v[0] !== 1'b0);
  endtask : run

  // ==========================================================
  // main sequence
  initial begin
    arst_n_in = 1'b0;
    avs_address_in = 8'h00;
    avs_read_in = 1'b0;
    avs_write_in = 1'b0;
    avs_writedata_in = 32'h0;
    avs_byteenable_in = 4'hf;
    errors = 0;
    checks = 0;
    repeat (12) @(posedge clk_in);
    arst_n_in <= 1'b1;
    @(posedge clk_in);
    chk(cbc_pkg::OFS_PROG_CNT, 32'h0);
    chk(cbc_pkg::OFS_STATUS, 32'h0);
    chk(8'h3c, 32'h0);
    // call, register mode, counter above 64k
    wr(cbc_pkg::OFS_PROG_CNT, 32'h12345);
    wr(cbc_pkg::OFS_STK_PTR, 32'h00400);
    wr(cbc_pkg::OFS_STATUS, 32'h013f);
    wr(cbc_pkg::OFS_REG_VAL, 32'habcde);
    run(32'h01);
    chk(cbc_pkg::OFS_PROG_CNT, 32'h0bcde);
    chk(cbc_pkg::OFS_STK_PTR, 32'h003fe);
    chk(cbc_pkg::OFS_STK_DATA, 32'h2345);
    chk(cbc_pkg::OFS_STATUS, 32'h013f);
    // call, auto-increment
    wr(cbc_pkg::OFS_REG_VAL, 32'h10000);
    wr(cbc_pkg::OFS_SRC_VAL, 32'h4444);
    run(32'h51);
    chk(cbc_pkg::OFS_PROG_CNT, 32'h04444);
    chk(cbc_pkg::OFS_EFF_ADDR, 32'h10000);
    chk(cbc_pkg::OFS_REG_VAL, 32'h10002);
    // call, indexed with negative offset, then symbolic
    wr(cbc_pkg::OFS_OFFSET, 32'hfffe);
    run(32'h11);
    chk(cbc_pkg::OFS_EFF_ADDR, 32'h10000);
    wr(cbc_pkg::OFS_OFFSET, 32'h0010);
    run(32'h21);
    chk(cbc_pkg::OFS_EFF_ADDR, 32'h04454);
    wr(cbc_pkg::OFS_EFF_ADDR, 32'hffff);
    chk(cbc_pkg::OFS_EFF_ADDR, 32'h04454);
    // call, absolute then indirect: both still push
    wr(cbc_pkg::OFS_OFFSET, 32'h1234);
    run(32'h31);
    chk(cbc_pkg::OFS_EFF_ADDR, 32'h01234);
    run(32'h41);
    chk(cbc_pkg::OFS_EFF_ADDR, 32'h10002);
    chk(cbc_pkg::OFS_PROG_CNT, 32'h04444);
    // jump, immediate, byte bit set but ignored
    wr(cbc_pkg::OFS_SRC_VAL, 32'hbeef);
    run(32'h68);
    chk(cbc_pkg::OFS_PROG_CNT, 32'h0beef);
    chk(cbc_pkg::OFS_STK_PTR, 32'h003f4);
    chk(cbc_pkg::OFS_STATUS, 32'h013f);
    // destination clear, word then byte
    run(32'h02);
    chk(cbc_pkg::OFS_DST_RES, 32'h0);
    chk(cbc_pkg::OFS_EXEC_ST, 32'h2);
    run(32'h0a);
    chk(cbc_pkg::OFS_EXEC_ST, 32'h6);
    chk(cbc_pkg::OFS_STATUS, 32'h013f);
    // flag clears and compares
    for (int i = 0; i < 8; i++) begin
      wr(cbc_pkg::OFS_STATUS, {16'h0, tv[i][1]});
      wr(cbc_pkg::OFS_SRC_VAL, {16'h0, tv[i][2]});
      wr(cbc_pkg::OFS_DST_VAL, {16'h0, tv[i][3]});
      run({16'h0, tv[i][0]});
      chk(cbc_pkg::OFS_STATUS, {16'h0, tv[i][4]});
    end
    chk(cbc_pkg::OFS_REG_VAL, 32'h10002);
    chk(cbc_pkg::OFS_EXEC_ST, 32'h4);
    close_out();
  end
endmodule : cbc_exec_top_tb_top
